// >>> hw/art_pkg.sv
// Package: register map, field positions and constants of the auto-reload timer
package art_pkg;

    // Register indices; the byte address on the bus is four times the index
    localparam logic [7:0] IDX_MODE_CONTROL   = 8'hE5;
    localparam logic [7:0] IDX_FLAGS          = 8'hE6;
    localparam logic [7:0] IDX_CLOCK_EDGE_PS  = 8'hE7;
    localparam logic [7:0] IDX_RELOAD_CAPTURE = 8'hE9;
    localparam logic [7:0] IDX_COMPARE        = 8'hEA;
    localparam logic [7:0] IDX_COUNTER_LIVE   = 8'hEB;

    // Mode-control fields
    localparam int MC_LOAD_STROBE   = 7;
    localparam int MC_COUNT_ENABLE  = 6;
    localparam int MC_WAVE_OE       = 5;
    localparam int MC_EDGE_IRQ_EN   = 4;
    localparam int MC_MATCH_IRQ_EN  = 3;
    localparam int MC_WRAP_IRQ_EN   = 2;
    localparam int MC_MODE_HI       = 1;
    localparam int MC_MODE_LO       = 0;

    // Flag fields
    localparam int FL_EDGE  = 2;
    localparam int FL_MATCH = 1;
    localparam int FL_WRAP  = 0;

    // Clock / edge / prescale fields
    localparam int CE_PS_HI   = 7;
    localparam int CE_PS_LO   = 5;
    localparam int CE_EDGE_POL = 3;
    localparam int CE_EDGE_EN  = 2;
    localparam int CE_CS_HI   = 1;
    localparam int CE_CS_LO   = 0;
    localparam logic [7:0] CE_WRITABLE = 8'hEF;

    // Reset values
    localparam logic [7:0] MODE_CONTROL_RESET = 8'h00;
    localparam logic [7:0] REG_RESET          = 8'h00;
    localparam logic [7:0] COUNTER_MAX        = 8'hFF;

    // Internal divide-by-three terminal count
    localparam logic [1:0] DIV3_LAST = 2'h2;

    // Operating modes
    typedef enum logic [1:0] {
        ART_MODE_AUTO_RELOAD   = 2'h0,
        ART_MODE_CAPTURE       = 2'h1,
        ART_MODE_CAPTURE_RESET = 2'h2,
        ART_MODE_EXT_LOAD      = 2'h3
    } art_mode_t;

    // Counting clock sources
    typedef enum logic [1:0] {
        ART_CLK_INTERNAL = 2'h0,
        ART_CLK_DIV3     = 2'h1,
        ART_CLK_PIN      = 2'h2,
        ART_CLK_RESERVED = 2'h3
    } art_clk_t;

    // AHB-Lite constants
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic       HRESP_OKAY    = 1'h0;

endpackage

// >>> hw/art_timer.sv
// Auto-reload timer with prescaler, capture, external load and PWM output, AHB-Lite slave
// How it works
// - Mode bits 1-0 pick auto-reload, capture, capture-with-reset or external-edge load.
// - Writing one to the load bit loads counter from reload value; reads zero.
// - Count enable runs the counter; cleared, prescaler and counter hold.
// - Output enable gates the waveform onto the timer output pin.
// - Edge interrupt request is edge flag AND its enable.
// - Match interrupt request is match flag AND its enable.
// - Wrap interrupt request is wrap flag AND its enable.
// - Reset clears mode control: timer stopped, interrupts masked, auto-reload.
// - Writing zero clears a flag; writing one leaves it.
// - Every selected active input edge sets the edge flag.
// - Counter stepping onto the compare value sets the match flag.
// - Counter stepping from FFh (to 00h, or to the reload value in auto-reload mode) sets the wrap flag.
// - Prescale select gives division by two to the power of its value.
// - Changing prescale select only moves the tap, never the prescaler count.
// - Edge select: low bit enables detection, high bit picks rising or falling.
// - Clock select: internal, internal divided by three, input pin; 11 reserved.
// - Every counter load also clears the prescaler.
// - Writing 06h to flags clears only wrap, leaving the edge flag pending.
// - Counter view register reads and writes the counter while it runs.
// - In auto-reload mode a wrap reloads the counter from the reload value.
// - Waveform goes high on wrap and low on compare match, every mode.
// - Capture mode copies the counter into the reload register on each edge.
// - Capture-with-reset mode also clears counter and prescaler on each edge.
// - External-load mode copies the reload value into the counter on each edge.
`timescale 1ns/1ps

module art_timer (
    input  wire logic        CLOCK,
    input  wire logic        SRST,
    input  wire logic        HSEL,
    input  wire logic [31:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    output logic      [31:0] HRDATA,
    output logic             HREADYOUT,
    output logic             HRESP,
    input  wire logic        TIMER_INPUT_PIN,
    output logic             TIMER_OUTPUT_PIN,
    output logic             TIMER_IRQ
);

    // All state of the block in one record
    typedef struct packed {
        logic [7:0]  mode_control;
        logic [2:0]  flags;
        logic [7:0]  clock_edge_prescale;
        logic [7:0]  reload_capture;
        logic [7:0]  compare;
        logic [7:0]  main_counter;
        logic [6:0]  prescaler_count;
        logic [1:0]  div3_count;
        logic        pin_meta;
        logic        pin_sync;
        logic        pin_prev;
        logic        wave;
        logic        pin_out;
        logic        irq;
        logic        wr_pending;
        logic        rd_pending;
        logic [7:0]  dp_index;
        logic [31:0] rdata;
        logic        ready;
    } art_state_t;

    art_state_t st;
    art_state_t next_st;

    // Register read multiplexer; unmapped words read as zero
    function automatic logic [31:0] read_reg(input art_state_t s, input logic [7:0] idx);
        logic [7:0] v;
        v = 8'h00;
        unique case (idx)
            art_pkg::IDX_MODE_CONTROL:   v = {1'b0, s.mode_control[6:0]};
            art_pkg::IDX_FLAGS:          v = {5'h00, s.flags};
            art_pkg::IDX_CLOCK_EDGE_PS:  v = s.clock_edge_prescale;
            art_pkg::IDX_RELOAD_CAPTURE: v = s.reload_capture;
            art_pkg::IDX_COMPARE:        v = s.compare;
            art_pkg::IDX_COUNTER_LIVE:   v = s.main_counter;
            default:                     v = 8'h00;
        endcase
        return {24'h000000, v};
    endfunction

    // Tap of the prescaler: all low n bits set means the selected divider rolls over
    function automatic logic tap_hit(input logic [6:0] cnt, input logic [2:0] sel);
        logic [6:0] mask;
        mask = 7'(8'hFF >> (4'h8 - {1'b0, sel}));
        return (cnt & mask) == mask;
    endfunction

    logic       addr_take;
    logic [7:0] wd;
    logic       tick;
    logic       step;
    logic       edge_seen;
    logic [7:0] counter_inc;
    logic       wraps;
    art_pkg::art_mode_t mode;
    art_pkg::art_clk_t  clk_sel;

    always_comb begin
        next_st   = st;
        wd        = HWDATA[7:0];
        mode      = art_pkg::art_mode_t'(st.mode_control[art_pkg::MC_MODE_HI:art_pkg::MC_MODE_LO]);
        clk_sel   = art_pkg::art_clk_t'(st.clock_edge_prescale[art_pkg::CE_CS_HI:art_pkg::CE_CS_LO]);
        addr_take = HSEL && HREADY && (HTRANS == art_pkg::HTRANS_NONSEQ);
        tick      = 1'b0;
        step      = 1'b0;
        edge_seen = 1'b0;
        wraps     = 1'b0;

        // Pin synchroniser; only the second stage and its delayed copy feed logic
        next_st.pin_meta = TIMER_INPUT_PIN;
        next_st.pin_sync = st.pin_meta;
        next_st.pin_prev = st.pin_sync;

        // Active edge detection on the synchronised pin
        if (st.clock_edge_prescale[art_pkg::CE_EDGE_EN]) begin
            if (st.clock_edge_prescale[art_pkg::CE_EDGE_POL])
                edge_seen = st.pin_prev && !st.pin_sync;
            else
                edge_seen = !st.pin_prev && st.pin_sync;
        end

        // Divide-by-three runs freely so its phase does not depend on the enable
        next_st.div3_count = (st.div3_count == art_pkg::DIV3_LAST) ? 2'h0 : st.div3_count + 2'h1;

        // Counting clock multiplexer; pin clock counts synchronised rising edges
        unique case (clk_sel)
            art_pkg::ART_CLK_INTERNAL: tick = 1'b1;
            art_pkg::ART_CLK_DIV3:     tick = (st.div3_count == art_pkg::DIV3_LAST);
            art_pkg::ART_CLK_PIN:      tick = !st.pin_prev && st.pin_sync;
            art_pkg::ART_CLK_RESERVED: tick = 1'b0;
        endcase

        // Prescaler and counter advance only while enabled, else both hold
        counter_inc = st.main_counter + 8'h01;
        if (st.mode_control[art_pkg::MC_COUNT_ENABLE] && tick) begin
            next_st.prescaler_count = st.prescaler_count + 7'h01;
            step = tap_hit(st.prescaler_count,
                           st.clock_edge_prescale[art_pkg::CE_PS_HI:art_pkg::CE_PS_LO]);
        end
        if (step) begin
            if (st.main_counter == art_pkg::COUNTER_MAX) begin
                wraps = 1'b1;
                if (mode == art_pkg::ART_MODE_AUTO_RELOAD) begin
                    next_st.main_counter    = st.reload_capture;
                    next_st.prescaler_count = 7'h00;
                end else begin
                    next_st.main_counter = 8'h00;
                end
            end else begin
                next_st.main_counter = counter_inc;
            end
        end

        // Waveform set on wrap, cleared on match; match wins if both coincide
        if (wraps)
            next_st.wave = 1'b1;
        if (step && (next_st.main_counter == st.compare))
            next_st.wave = 1'b0;

        // Edge actions by mode
        if (edge_seen) begin
            unique case (mode)
                art_pkg::ART_MODE_CAPTURE: begin
                    next_st.reload_capture = st.main_counter;
                end
                art_pkg::ART_MODE_CAPTURE_RESET: begin
                    next_st.reload_capture  = st.main_counter;
                    next_st.main_counter    = 8'h00;
                    next_st.prescaler_count = 7'h00;
                end
                art_pkg::ART_MODE_EXT_LOAD: begin
                    next_st.main_counter    = st.reload_capture;
                    next_st.prescaler_count = 7'h00;
                end
                art_pkg::ART_MODE_AUTO_RELOAD: begin
                end
            endcase
        end

        // Flags: software clears by writing zero, hardware set wins the same cycle
        if (st.wr_pending && st.dp_index == art_pkg::IDX_FLAGS)
            next_st.flags = st.flags & wd[2:0];
        if (edge_seen)
            next_st.flags[art_pkg::FL_EDGE] = 1'b1;
        if (step && (next_st.main_counter == st.compare))
            next_st.flags[art_pkg::FL_MATCH] = 1'b1;
        if (wraps)
            next_st.flags[art_pkg::FL_WRAP] = 1'b1;

        // Bus writes land in the data phase; software loads override timer events
        if (st.wr_pending) begin
            unique case (st.dp_index)
                art_pkg::IDX_MODE_CONTROL: begin
                    next_st.mode_control = {1'b0, wd[6:0]};
                    if (wd[art_pkg::MC_LOAD_STROBE]) begin
                        next_st.main_counter    = st.reload_capture;
                        next_st.prescaler_count = 7'h00;
                    end
                end
                art_pkg::IDX_CLOCK_EDGE_PS:  next_st.clock_edge_prescale = wd & art_pkg::CE_WRITABLE;
                art_pkg::IDX_RELOAD_CAPTURE: next_st.reload_capture = wd;
                art_pkg::IDX_COMPARE:        next_st.compare = wd;
                art_pkg::IDX_COUNTER_LIVE: begin
                    next_st.main_counter    = wd;
                    next_st.prescaler_count = 7'h00;
                end
                default: begin
                end
            endcase
        end

        // Registered outputs
        next_st.pin_out = next_st.wave && next_st.mode_control[art_pkg::MC_WAVE_OE];
        next_st.irq = (next_st.flags[art_pkg::FL_EDGE]  && next_st.mode_control[art_pkg::MC_EDGE_IRQ_EN])
                   || (next_st.flags[art_pkg::FL_MATCH] && next_st.mode_control[art_pkg::MC_MATCH_IRQ_EN])
                   || (next_st.flags[art_pkg::FL_WRAP]  && next_st.mode_control[art_pkg::MC_WRAP_IRQ_EN]);

        // Bus slave: writes take no wait state, reads take one so a prior write is seen
        next_st.wr_pending = 1'b0;
        if (st.rd_pending) begin
            next_st.rdata      = read_reg(next_st, st.dp_index);
            next_st.ready      = 1'b1;
            next_st.rd_pending = 1'b0;
        end else if (addr_take) begin
            next_st.dp_index   = HADDR[9:2];
            next_st.wr_pending = HWRITE && (HADDR[31:10] == 22'h000000);
            next_st.rd_pending = !HWRITE;
            next_st.ready      = HWRITE;
            if (!HWRITE && HADDR[31:10] != 22'h000000)
                next_st.dp_index = 8'h00;
        end
    end

    // State register; reset clears everything but ready, which it sets; mode control included
    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            st              <= '0;
            st.mode_control <= art_pkg::MODE_CONTROL_RESET;
            st.ready        <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign HRDATA           = st.rdata;
    assign HREADYOUT        = st.ready;
    assign HRESP            = art_pkg::HRESP_OKAY;
    assign TIMER_OUTPUT_PIN = st.pin_out;
    assign TIMER_IRQ        = st.irq;

endmodule

// >>> sim/art_assertions.sv
// Checker on the timer's top-level ports: bus timing, read-back and pin gating
`timescale 1ns/1ps
module art_assertions (
    input  wire logic        CLOCK,
    input  wire logic        SRST,
    input  wire logic        HSEL,
    input  wire logic [31:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    input  wire logic [31:0] HRDATA,
    input  wire logic        HREADYOUT,
    input  wire logic        HRESP,
    input  wire logic        TIMER_OUTPUT_PIN,
    input  wire logic        TIMER_IRQ
);
    logic take;
    logic wr_mode;
    logic is_mode;

    // Transfer accepted in this address phase
    assign take    = HSEL && HREADY && HTRANS == art_pkg::HTRANS_NONSEQ;
    assign is_mode = HADDR[9:2] == art_pkg::IDX_MODE_CONTROL;

    // Flags the data phase of a mode write, where its data stands
    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            wr_mode <= 1'b0;
        end else begin
            wr_mode <= take && HWRITE && is_mode;
        end
    end

    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (SRST);

    sequence one_wait;
        !HREADYOUT ##1 HREADYOUT;
    endsequence

    chk_read_wait: assert property (take && !HWRITE |=> one_wait)
        else $error("read did not take exactly one wait cycle");
    chk_write_nowait: assert property (take && HWRITE |=> HREADYOUT)
        else $error("write data phase stalled");
    chk_resp_okay: assert property (HRESP == art_pkg::HRESP_OKAY)
        else $error("slave answered other than OKAY");
    chk_rdata_upper: assert property (take && !HWRITE |-> ##2 HRDATA[31:8] == 24'h000000)
        else $error("read data above the byte not zero");
    chk_load_reads_zero: assert property (take && !HWRITE && is_mode |-> ##2 !HRDATA[7])
        else $error("load bit read back as one");
    chk_reset_quiet: assert property ($fell(SRST) |-> HREADYOUT && !TIMER_IRQ && !TIMER_OUTPUT_PIN)
        else $error("outputs not quiet after reset");
    chk_oe_gate: assert property (wr_mode && !HWDATA[5] |=> ##1 !TIMER_OUTPUT_PIN)
        else $error("waveform on the pin with output disabled");
    chk_irq_masked: assert property (wr_mode && HWDATA[4:2] == 3'h0 |=> ##1 !TIMER_IRQ)
        else $error("interrupt raised with all enables clear");
endmodule

// >>> sim/art_pin_model.sv
// Pin-side partner: source of edges and clock pulses on the timer input
`timescale 1ns/1ps
module art_pin_model (
    input  wire logic CLOCK,
    output logic      TIMER_INPUT_PIN
);
    initial TIMER_INPUT_PIN = 1'b0;

    // One pulse; both levels held for whole clocks so the synchroniser sees them
    task automatic pulse(input int hi, input int lo);
        TIMER_INPUT_PIN <= 1'b1;
        repeat (hi) @(posedge CLOCK);
        TIMER_INPUT_PIN <= 1'b0;
        repeat (lo) @(posedge CLOCK);
    endtask
endmodule

// >>> sim/testbench.sv
// Bench for the auto-reload timer: registers, counting, flags, waveform, edges
`timescale 1ns/1ps
module testbench;
    localparam logic [7:0] mc = art_pkg::IDX_MODE_CONTROL;
    localparam logic [7:0] fl = art_pkg::IDX_FLAGS;
    localparam logic [7:0] ce = art_pkg::IDX_CLOCK_EDGE_PS;
    localparam logic [7:0] rc = art_pkg::IDX_RELOAD_CAPTURE;
    localparam logic [7:0] cp = art_pkg::IDX_COMPARE;
    localparam logic [7:0] cv = art_pkg::IDX_COUNTER_LIVE;
    logic        clock  = 1'b0;
    logic        srst   = 1'b1;
    logic        hsel   = 1'b0;
    logic [31:0] haddr  = 32'h00000000;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h00000000;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        pin_in;
    logic        pin_out;
    logic        irq;
    logic [31:0] rd;
    int          err_count = 0;
    int          cmp_count = 0;
    int          n;

    always #5 clock = ~clock;

    art_timer art_timer_inst (.CLOCK(clock), .SRST(srst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
        .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
        .HREADYOUT(hreadyout), .HRESP(), .TIMER_INPUT_PIN(pin_in), .TIMER_OUTPUT_PIN(pin_out),
        .TIMER_IRQ(irq));
    art_pin_model art_pin_model_inst (.CLOCK(clock), .TIMER_INPUT_PIN(pin_in));

    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Bounded wait for the slave to end the current phase
    task automatic ready_wait();
        int k;
        k = 0;
        do begin
            @(posedge clock);
            k++;
        end while (hreadyout !== 1'b1 && k < 40);
        if (hreadyout !== 1'b1) begin
            err_count++;
            end_of_test();
        end
    endtask

    // One single AHB-Lite transfer; read data taken at the closing edge
    task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] wd);
        hsel   <= 1'b1;
        htrans <= art_pkg::HTRANS_NONSEQ;
        hwrite <= w;
        haddr  <= {22'h000000, idx, 2'h0};
        ready_wait();
        htrans <= 2'h0;
        hwdata <= {24'h000000, wd};
        ready_wait();
        rd = hrdata;
    endtask

    task automatic rdc(input string what, input logic [7:0] idx, input logic [7:0] exp);
        bus(1'b0, idx, 8'h00);
        chk(what, {24'h000000, exp}, rd);
    endtask

    // Counts clocks until the output pin shows the given level
    task automatic pin_wait(input logic lvl);
        n = 0;
        while (pin_out !== lvl && n < 300) begin
            @(posedge clock);
            n++;
        end
        // A pin that never toggles is a hang, not a width
        if (pin_out !== lvl) begin
            err_count++;
            end_of_test();
        end
    endtask

    initial begin
        repeat (12) @(posedge clock);
        srst <= 1'b0;
        rdc("mode after reset", mc, 8'h00);
        rdc("unmapped read", 8'h20, 8'h00);
        bus(1'b1, ce, 8'hED);
        rdc("clock config", ce, 8'hED);
        bus(1'b1, mc, 8'hBF);
        rdc("mode readback", mc, 8'h3F);
        bus(1'b1, mc, 8'h00);
        // Run for a known number of clocks at every prescale tap
        for (int p = 0; p < 8; p++) begin
            bus(1'b1, ce, 8'(p << 5));
            bus(1'b1, cv, 8'h00);
            bus(1'b1, mc, 8'h40);
            repeat (3 * (1 << p) + (1 << p) / 2 - 2) @(posedge clock);
            bus(1'b1, mc, 8'h00);
            rdc("prescaled count", cv, 8'h03);
        end
        bus(1'b1, ce, 8'h01);
        bus(1'b1, cv, 8'h00);
        bus(1'b1, mc, 8'h40);
        repeat (28) @(posedge clock);
        bus(1'b1, mc, 8'h00);
        rdc("divide by three count", cv, 8'h0A);
        bus(1'b1, ce, 8'h02);
        bus(1'b1, cv, 8'h00);
        bus(1'b1, mc, 8'h40);
        repeat (5) art_pin_model_inst.pulse(3, 3);
        bus(1'b1, mc, 8'h00);
        rdc("pin clock count", cv, 8'h05);
        // Waveform: reload F0, compare F8, every step one clock
        bus(1'b1, ce, 8'h00);
        bus(1'b1, rc, 8'hF0);
        bus(1'b1, cp, 8'hF8);
        bus(1'b1, mc, 8'hEC);
        pin_wait(1'b1);
        pin_wait(1'b0);
        chk("high width", 32'd8, n);
        pin_wait(1'b1);
        chk("low width", 32'd8, n);
        bus(1'b1, mc, 8'h0C);
        rdc("flags after run", fl, 8'h03);
        chk("irq match and wrap", 32'h1, {31'h0, irq});
        bus(1'b1, ce, 8'h04);
        art_pin_model_inst.pulse(4, 4);
        rdc("flags after rising edge", fl, 8'h07);
        bus(1'b1, fl, 8'h06);
        rdc("flags after 06h", fl, 8'h06);
        bus(1'b1, mc, 8'h10);
        // Look once the mode write has settled, not at its launching edge
        @(negedge clock);
        chk("irq on edge", 32'h1, {31'h0, irq});
        bus(1'b1, fl, 8'h03);
        rdc("edge flag cleared", fl, 8'h02);
        chk("irq edge cleared", 32'h0, {31'h0, irq});
        bus(1'b1, ce, 8'h0C);
        art_pin_model_inst.pulse(4, 4);
        rdc("falling edge flag", fl, 8'h06);
        bus(1'b1, fl, 8'h00);
        bus(1'b1, ce, 8'h08);
        art_pin_model_inst.pulse(4, 4);
        rdc("detection off", fl, 8'h00);
        // Edge actions of the three pin modes, with the counter stopped
        bus(1'b1, ce, 8'h04);
        for (int m = 1; m < 4; m++) begin
            bus(1'b1, rc, 8'h5A);
            bus(1'b1, cv, 8'h77);
            bus(1'b1, mc, 8'(m));
            art_pin_model_inst.pulse(4, 4);
            rdc("reload after edge", rc, m == 3 ? 8'h5A : 8'h77);
            rdc("counter after edge", cv, m == 1 ? 8'h77 : (m == 2 ? 8'h00 : 8'h5A));
        end
        end_of_test();
    end
endmodule

bind art_timer art_assertions art_assertions_inst (.CLOCK(CLOCK), .SRST(SRST), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .TIMER_OUTPUT_PIN(TIMER_OUTPUT_PIN), .TIMER_IRQ(TIMER_IRQ));
